// file: include/csu_pkg.sv
// constants, modes and register layout of the clock source control unit
// assumes a 32-bit APB host and source edges given as pclk-wide ticks
//
// Behaviour
// R1: bus divider field divides the selected source by 1, 2, 4, 8; resets to 2
// R2: range bit drives the oscillator high or low frequency range request
// R3: gain bit selects high gain or low power oscillator operation
// R4: low power bit disables the loop in bypassed modes unless debug is active
// R5: source select bit requests crystal oscillator or a direct external clock
// R6: external reference clock output runs only while its enable bit is one
// R7: in stop the external reference survives only with stop enable set
// R8: eight-bit coarse trim, binary weighted, larger value gives longer period
// R9: fine trim is the lowest step of the internal reference period
// R10: two-bit mode status follows the switched clock, not the write itself
// R11: oscillator ready sets after init when crystal is used, clears on disable
// R12: reset and select 00 with internal reference give loop engaged internal; the code also needs ref_freq_ok for select 00
// R13: engaged modes clock from the loop, locked to 512 times, debug clock on
// R14: select 00 with external reference in range gives loop engaged external
// R15: select 01, internal, debug or low power off gives bypassed internal
// R16: select 01, internal, no debug, low power on gives bypassed low power
// R17: clock select picks loop, internal or external; fourth code acts as loop
// R18: loop reference is internal when the select bit is one, else external
// R19: reference divider divides the loop reference by 1 to 128; resets to 1
// R20: mode status and ready flag are read only; fine trim stays writable
package csu_pkg;
  localparam logic [3:0] OFS_SRC = 4'h0;
  localparam logic [3:0] OFS_C2 = 4'h4;
  localparam logic [3:0] OFS_TRIM = 4'h8;
  localparam logic [3:0] OFS_SC = 4'hC;
  localparam int BUS_DIV_HI = 7;
  localparam int BUS_DIV_LO = 6;
  localparam int RANGE_B = 5;
  localparam int GAIN_B = 4;
  localparam int LOW_PWR_B = 3;
  localparam int SRC_SEL_B = 2;
  localparam int EXT_EN_B = 1;
  localparam int ERSTEN_B = 0;
  localparam int CLK_SEL_HI = 7;
  localparam int CLK_SEL_LO = 6;
  localparam int REF_DIV_HI = 5;
  localparam int REF_DIV_LO = 3;
  localparam int INT_REF_B = 2;
  localparam int STATUS_HI = 3;
  localparam int STATUS_LO = 2;
  localparam int OSCRDY_B = 1;
  localparam int FINE_B = 0;
  localparam logic [7:0] C2_RST = 8'h40;
  localparam logic [7:0] SRC_RST = 8'h04;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic FINE_RST = 1'b0;
  localparam logic [2:0] SWITCH_TICKS = 3'h4;
  localparam logic [9:0] LOOP_MULT = 10'h200;
  localparam logic [1:0] SEL_LOOP = 2'h0;
  localparam logic [1:0] SEL_INT = 2'h1;
  localparam logic [1:0] SEL_EXT = 2'h2;
  typedef enum logic [5:0] {
    CSU_ENG_INT = 6'h01,
    CSU_ENG_EXT = 6'h02,
    CSU_BYP_INT = 6'h04,
    CSU_BYP_INT_LP = 6'h08,
    CSU_BYP_EXT = 6'h10,
    CSU_BYP_EXT_LP = 6'h20
  } csu_mode_e;
  // returns {valid, index}; word aligned, first 16 bytes only
  function automatic logic [2:0] csu_reg_index(input logic [31:0] a);
    csu_reg_index = {(a[31:4] == 28'h0) && (a[1:0] == 2'h0), a[3:2]};
  endfunction
endpackage

// file: include/csu_reg_if.sv
// register strobe carrier between bus slave and clock control core
// assumes one pclk domain on both ends
`timescale 1ns/1ps
`default_nettype none
interface csu_reg_if;
  logic wr_stb;
  logic [1:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport apb (output wr_stb, output idx, output wdata, input rdata);
  modport core (input wr_stb, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/csu_apb.sv
// APB slave for the clock control registers, no wait states
// assumes the core returns read data for the index combinationally
`timescale 1ns/1ps
`default_nettype none
module csu_apb
  import csu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  csu_reg_if.apb bus
);
  logic [2:0] dec;
  logic [31:0] prdata_r;

  assign dec = csu_reg_index(paddr);
  assign bus.idx = dec[1:0];
  assign bus.wdata = pwdata[7:0];
  // only the low lane holds register bits
  assign bus.wr_stb = psel & penable & pwrite & dec[2] & pstrb[0];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~dec[2];
  assign prdata = prdata_r;

  // data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (psel & ~penable) begin
      prdata_r <= dec[2] ? {24'h0, bus.rdata} : 32'h0;
    end
  end
endmodule // csu_apb
`default_nettype wire

// file: rtl/csu_top.sv
// clock source control: registers, mode sequencer, dividers, osc controls
// assumes source edges arrive as one-cycle ticks synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module csu_top
  import csu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_ref_tick,
  input wire logic ext_ref_tick,
  input wire logic loop_tick,
  input wire logic background_debug_active,
  input wire logic stop_mode,
  input wire logic ref_freq_ok,
  input wire logic osc_init_done,
  output logic main_clock_out,
  output logic debug_clock_out,
  output logic ext_ref_clock_out,
  output logic ref_div_tick,
  output logic ext_ref_osc_en,
  output logic osc_range_high,
  output logic osc_high_gain,
  output logic ext_source_select,
  output logic loop_enable,
  output logic loop_ref_internal,
  output logic [9:0] loop_multiplier,
  output logic [8:0] int_ref_trim,
  output logic [1:0] mode_status
);
  csu_reg_if bus ();

  logic [7:0] src_r;
  logic [7:0] c2_r;
  logic [7:0] trim_r;
  logic fine_trim_r;
  logic osc_ready_r;
  csu_mode_e mode_r;
  csu_mode_e pend_r;
  csu_mode_e target;
  logic [2:0] sw_cnt_r;
  logic [2:0] bus_cnt_r;
  logic [6:0] ref_cnt_r;
  logic main_tick_r;
  logic dbg_tick_r;
  logic ext_tick_r;
  logic ref_tick_r;
  logic [1:0] status_nxt;
  logic [1:0] clock_select;
  logic [2:0] ref_divider;
  logic int_ref_select;
  logic [1:0] bus_divider;
  logic low_power_select;
  logic ext_ref_enable;
  logic ext_ref_stop_enable;
  logic ext_mode;
  logic bypass_mode;
  logic src_tick;
  logic pend_tick;
  logic ref_src_tick;
  logic [2:0] bus_ratio;
  logic [6:0] ref_ratio;
  logic wr_src;
  logic wr_c2;
  logic wr_trim;
  logic wr_sc;
  logic osc_clr;

  csu_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus)
  );

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  assign wr_src = bus.wr_stb & (bus.idx == OFS_SRC[3:2]);
  assign wr_c2 = bus.wr_stb & (bus.idx == OFS_C2[3:2]);
  assign wr_trim = bus.wr_stb & (bus.idx == OFS_TRIM[3:2]);
  assign wr_sc = bus.wr_stb & (bus.idx == OFS_SC[3:2]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= SRC_RST;
    end else if (wr_src) begin
      src_r <= bus.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c2_r <= C2_RST; // R1
    end else if (wr_c2) begin
      c2_r <= bus.wdata;
    end
  end

  // trim has a defined reset so the reference starts mid range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_r <= TRIM_RST;
      fine_trim_r <= FINE_RST;
    end else begin
      if (wr_trim) begin
        trim_r <= bus.wdata;
      end
      if (wr_sc) begin
        fine_trim_r <= bus.wdata[FINE_B]; // R20
      end
    end
  end

  always_comb begin
    bus.rdata = 8'h0;
    unique case (bus.idx)
      OFS_SRC[3:2]: bus.rdata = src_r;
      OFS_C2[3:2]: bus.rdata = c2_r;
      OFS_TRIM[3:2]: bus.rdata = trim_r;
      OFS_SC[3:2]: begin
        bus.rdata[STATUS_HI:STATUS_LO] = mode_status; // R20
        bus.rdata[OSCRDY_B] = osc_ready_r;
        bus.rdata[FINE_B] = fine_trim_r;
      end
    endcase
  end

  assign clock_select = src_r[CLK_SEL_HI:CLK_SEL_LO];
  assign ref_divider = src_r[REF_DIV_HI:REF_DIV_LO];
  assign int_ref_select = src_r[INT_REF_B];
  assign bus_divider = c2_r[BUS_DIV_HI:BUS_DIV_LO];
  assign low_power_select = c2_r[LOW_PWR_B];
  assign ext_ref_enable = c2_r[EXT_EN_B];
  assign ext_ref_stop_enable = c2_r[ERSTEN_B];

  // ------------------------------------------------------------
  // oscillator controls and trim
  // ------------------------------------------------------------
  assign osc_range_high = c2_r[RANGE_B]; // R2
  assign osc_high_gain = c2_r[GAIN_B]; // R3
  assign ext_source_select = c2_r[SRC_SEL_B]; // R5
  assign int_ref_trim = {trim_r, fine_trim_r}; // R8 R9
  assign loop_multiplier = LOOP_MULT; // R13
  assign loop_ref_internal = int_ref_select; // R18

  assign ext_mode = (mode_r == CSU_ENG_EXT) | (mode_r == CSU_BYP_EXT) |
                    (mode_r == CSU_BYP_EXT_LP);
  assign bypass_mode = (mode_r != CSU_ENG_INT) & (mode_r != CSU_ENG_EXT);

  // oscillator keeps running in stop only when asked to
  assign ext_ref_osc_en = stop_mode ?
      (ext_ref_stop_enable & (ext_ref_enable | ext_mode)) :
      (ext_ref_enable | ext_mode); // R7 R14

  // R4 R15 R16: loop shuts off in low power bypass without debug
  assign loop_enable = ~stop_mode &
      ~(bypass_mode & low_power_select & ~background_debug_active);

  // set beats clear when both land in one cycle
  assign osc_clr = ~ext_ref_enable | ~ext_source_select;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ready_r <= 1'b0;
    end else if (osc_init_done & ext_source_select &
                 (ext_ref_enable | ext_mode)) begin
      osc_ready_r <= 1'b1; // R11
    end else if (osc_clr) begin
      osc_ready_r <= 1'b0; // R11
    end
  end

  // ------------------------------------------------------------
  // mode sequencer
  // ------------------------------------------------------------
  // mismatched select pairs keep the present mode
  always_comb begin
    target = mode_r;
    unique case (clock_select)
      SEL_INT: begin
        if (int_ref_select) begin
          target = (background_debug_active | ~low_power_select) ?
                   CSU_BYP_INT : CSU_BYP_INT_LP; // R15 R16
        end
      end
      SEL_EXT: begin
        if (!int_ref_select) begin
          target = (background_debug_active | ~low_power_select) ?
                   CSU_BYP_EXT : CSU_BYP_EXT_LP;
        end
      end
      default: begin
        if (ref_freq_ok) begin
          target = int_ref_select ? CSU_ENG_INT : CSU_ENG_EXT; // R12 R14 R17
        end
      end
    endcase
  end

  always_comb begin
    pend_tick = loop_tick;
    unique case (pend_r)
      CSU_ENG_INT, CSU_ENG_EXT: pend_tick = loop_tick;
      CSU_BYP_INT, CSU_BYP_INT_LP: pend_tick = int_ref_tick;
      CSU_BYP_EXT, CSU_BYP_EXT_LP: pend_tick = ext_ref_tick;
      default: pend_tick = loop_tick;
    endcase
  end

  // switch waits for a few edges of the new source; no edges, no switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= CSU_ENG_INT;
      sw_cnt_r <= 3'h0;
    end else if (target != pend_r) begin
      pend_r <= target;
      sw_cnt_r <= 3'h0;
    end else if ((pend_r != mode_r) & pend_tick) begin
      sw_cnt_r <= sw_cnt_r + 3'h1;
    end else if (pend_r == mode_r) begin
      sw_cnt_r <= 3'h0;
    end
  end

  // power-related flavour changes also wait for four edges of the unchanged source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= CSU_ENG_INT; // R12
    end else if ((target == pend_r) & (pend_r != mode_r) & pend_tick &
                 (sw_cnt_r == SWITCH_TICKS - 3'h1)) begin
      mode_r <= pend_r; // R10
    end
  end

  always_comb begin
    status_nxt = SEL_LOOP;
    unique case (mode_r)
      CSU_ENG_INT, CSU_ENG_EXT: status_nxt = SEL_LOOP; // R13
      CSU_BYP_INT, CSU_BYP_INT_LP: status_nxt = SEL_INT;
      CSU_BYP_EXT, CSU_BYP_EXT_LP: status_nxt = SEL_EXT;
      default: status_nxt = SEL_LOOP;
    endcase
  end
  assign mode_status = status_nxt; // R10

  // ------------------------------------------------------------
  // bus divider and reference divider
  // ------------------------------------------------------------
  always_comb begin
    src_tick = loop_tick;
    unique case (status_nxt)
      SEL_INT: src_tick = int_ref_tick;
      SEL_EXT: src_tick = ext_ref_tick;
      default: src_tick = loop_tick; // R17
    endcase
  end

  assign bus_ratio = 3'((4'h1 << bus_divider) - 4'h1); // R1
  assign ref_ratio = 7'((8'h1 << ref_divider) - 8'h1); // R19
  assign ref_src_tick = int_ref_select ? int_ref_tick : ext_ref_tick;

  // divider changes act at once; the count restarts if past the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_cnt_r <= 3'h0;
      main_tick_r <= 1'b0;
    end else begin
      main_tick_r <= 1'b0;
      if (stop_mode) begin
        bus_cnt_r <= 3'h0;
      end else if (src_tick) begin
        if (bus_cnt_r >= bus_ratio) begin
          bus_cnt_r <= 3'h0;
          main_tick_r <= 1'b1; // R1
        end else begin
          bus_cnt_r <= bus_cnt_r + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_r <= 7'h0;
      ref_tick_r <= 1'b0;
    end else begin
      ref_tick_r <= 1'b0;
      if (ref_src_tick) begin
        if (ref_cnt_r >= ref_ratio) begin
          ref_cnt_r <= 7'h0;
          ref_tick_r <= 1'b1; // R19
        end else begin
          ref_cnt_r <= ref_cnt_r + 7'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // gated clock outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_tick_r <= 1'b0;
      ext_tick_r <= 1'b0;
    end else begin
      dbg_tick_r <= loop_tick & loop_enable; // R13 R16
      ext_tick_r <= ext_ref_tick & ext_ref_enable &
                    (~stop_mode | ext_ref_stop_enable); // R6 R7
    end
  end

  assign main_clock_out = main_tick_r;
  assign debug_clock_out = dbg_tick_r;
  assign ext_ref_clock_out = ext_tick_r;
  assign ref_div_tick = ref_tick_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_div_reset: assert property ($rose(presetn) |-> c2_r[7:6] == 2'h1) // R1
    else $error("bus divider not at divide by two after reset");
  a_div1_each: assert property ((bus_divider == 2'h0) & src_tick &
      ~stop_mode & $stable(bus_divider) |=> main_clock_out) // R1
    else $error("divide by one missed a source edge");
  a_tick_cause: assert property (main_clock_out |-> $past(src_tick)) // R1
    else $error("bus tick without a source edge");
  a_pwr_loop_off: assert property (bypass_mode & low_power_select &
      ~background_debug_active |-> ~loop_enable) // R4
    else $error("loop left on in low power bypass");
  a_ext_gate: assert property (~ext_ref_enable |=> ~ext_ref_clock_out) // R6
    else $error("external reference out while disabled");
  a_stop_ext: assert property (stop_mode & ~ext_ref_stop_enable |->
      ~ext_ref_osc_en) // R7
    else $error("external reference kept in stop");
  a_trim_map: assert property (int_ref_trim[0] == fine_trim_r &&
      int_ref_trim[8:1] == trim_r) // R8
    else $error("trim bits out of place");
  a_osc_clear: assert property (osc_clr & ~osc_init_done |=>
      ~osc_ready_r) // R11
    else $error("ready flag survived disable");
  a_sc_ro: assert property (wr_sc |=> $stable(osc_ready_r) ||
      $past(osc_init_done) || $past(osc_clr)) // R20
    else $error("status write changed ready flag");
  a_status_lag: assert property ($changed(clock_select) &&
      mode_r == pend_r |=> $stable(mode_status)) // R10
    else $error("mode status jumped on write");
  // no debug while in low power bypass internal keeps the debug clock off
  a_lp_no_debug: assert property (mode_r == CSU_BYP_INT_LP &
      low_power_select & ~background_debug_active & ~stop_mode |=>
      ~debug_clock_out) // R16
    else $error("debug clock in bypassed low power");
  a_reset_engaged: assert property ($rose(presetn) |->
      mode_r == CSU_ENG_INT) // R12
    else $error("reset did not give engaged internal");

  c_to_byp_int: cover property (mode_r == CSU_ENG_INT ##[1:200]
      mode_r == CSU_BYP_INT);
  c_to_eng_ext: cover property (mode_r == CSU_ENG_INT ##[1:200]
      mode_r == CSU_ENG_EXT);
  c_osc_rdy: cover property ($rose(osc_ready_r));
  c_div8: cover property (bus_divider == 2'h3 & main_clock_out);
endmodule // csu_top
`default_nettype wire

// file: verification/csu_osc_model.sv
// external oscillator model: reference edges and init-done flag
// assumes its controls are synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module csu_osc_model #(
  parameter int PERIOD = 5,
  parameter int INIT_TICKS = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_en,
  input wire logic crystal,
  output logic ref_tick,
  output var logic init_done
);
  int div_cnt;
  int init_cnt;
  // ---------------------------------------------------------------
  // edges
  // ---------------------------------------------------------------
  // no edges while switched off, like a stopped crystal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 0;
      ref_tick <= 1'b0;
    end else begin
      div_cnt <= (osc_en && div_cnt < PERIOD - 1) ? div_cnt + 1 : 0;
      ref_tick <= osc_en && (div_cnt == PERIOD - 1);
    end
  end
  // ---------------------------------------------------------------
  // start-up
  // ---------------------------------------------------------------
  // a direct clock never reports ready, only a crystal does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) init_cnt <= 0;
    else if (!osc_en || !crystal) init_cnt <= 0;
    else if (ref_tick && init_cnt < INIT_TICKS) init_cnt <= init_cnt + 1;
  end
  assign init_done = (init_cnt == INIT_TICKS);
endmodule // csu_osc_model
`default_nettype wire

// file: verification/csu_top_tb.sv
// self-checking bench for the clock source control unit
// assumes the oscillator model beside it and APB with no wait states
`timescale 1ns/1ps
`default_nettype none
module csu_top_tb;
  import csu_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic int_ref_tick = 1'b0;
  logic loop_tick = 1'b0;
  logic ext_ref_tick, osc_init_done;
  logic dbg = 1'b0;
  logic stop_mode = 1'b0;
  logic ref_freq_ok = 1'b0;
  logic main_clock_out, debug_clock_out, ext_ref_clock_out, ref_div_tick;
  logic ext_ref_osc_en, osc_range_high, osc_high_gain, ext_source_select;
  logic loop_enable, loop_ref_internal;
  logic [9:0] loop_multiplier;
  logic [8:0] int_ref_trim;
  logic [1:0] mode_status;
  int bad_count = 0;
  int num_checks = 0;
  int tcnt = 0;
  int n_main, n_dbg, n_ext, n_rdt;
  logic [31:0] rv;
  logic er;

  always #2.5 pclk = ~pclk;

  // loop edges every 2 cycles, internal reference every 3
  always @(posedge pclk) begin
    tcnt <= tcnt + 1;
    loop_tick <= (tcnt % 2 == 0);
    int_ref_tick <= (tcnt % 3 == 0);
  end

  csu_top csu_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_ref_tick(int_ref_tick), .ext_ref_tick(ext_ref_tick),
    .loop_tick(loop_tick), .background_debug_active(dbg),
    .stop_mode(stop_mode), .ref_freq_ok(ref_freq_ok),
    .osc_init_done(osc_init_done), .main_clock_out(main_clock_out),
    .debug_clock_out(debug_clock_out),
    .ext_ref_clock_out(ext_ref_clock_out), .ref_div_tick(ref_div_tick),
    .ext_ref_osc_en(ext_ref_osc_en), .osc_range_high(osc_range_high),
    .osc_high_gain(osc_high_gain), .ext_source_select(ext_source_select),
    .loop_enable(loop_enable), .loop_ref_internal(loop_ref_internal),
    .loop_multiplier(loop_multiplier), .int_ref_trim(int_ref_trim),
    .mode_status(mode_status));

  csu_osc_model csu_osc_model_i (.pclk(pclk), .presetn(presetn),
    .osc_en(ext_ref_osc_en), .crystal(ext_source_select),
    .ref_tick(ext_ref_tick), .init_done(osc_init_done));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, seen, exp);
    end
  endtask

  task automatic near(input int seen, exp, input string m);
    check({31'h0, (seen >= exp - 1) && (seen <= exp + 1)}, 32'h1, m);
  endtask

  // holds the request until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) check({31'h0, pready}, 32'h1, "no pready");
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, {28'h0, a}, {24'h0, d});
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, string m);
    xfer(1'b0, {28'h0, a}, 32'h0);
    check(rv, {24'h0, e}, m);
  endtask

  task automatic measure(input int cyc);
    n_main = 0; n_dbg = 0; n_ext = 0; n_rdt = 0;
    // skip the edge that still carries the old setting
    @(posedge pclk);
    repeat (cyc) begin
      @(negedge pclk);
      n_main += main_clock_out;
      n_dbg += debug_clock_out;
      n_ext += ext_ref_clock_out;
      n_rdt += ref_div_tick;
    end
  endtask

  task automatic wait_mode(input logic [1:0] e, string m);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (mode_status !== e && n < 300);
    check({30'h0, mode_status}, {30'h0, e}, m);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_C2, C2_RST, "c2 reset");
    rd(OFS_SRC, SRC_RST, "src reset");
    rd(OFS_TRIM, TRIM_RST, "trim reset");
    rd(OFS_SC, 8'h00, "sc reset");
    xfer(1'b0, 32'h10, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped error");
    check(rv, 32'h0, "unmapped data");
    $display("reset test done");
  endtask

  task automatic t_bus_div;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_C2, 8'(k << 6));
      measure(256);
      near(n_main, 128 >> k, "bus divider");
      near(n_dbg, 128, "debug clock");
    end
    wr(OFS_C2, 8'h40);
    $display("bus divider test done");
  endtask

  task automatic t_osc_bits;
    for (int v = 0; v < 16; v++) begin
      wr(OFS_C2, 8'h40 | 8'(v << 2));
      @(negedge pclk);
      check({31'h0, osc_range_high}, v[3], "range");
      check({31'h0, osc_high_gain}, v[2], "gain");
      check({31'h0, ext_source_select}, v[0], "source");
      check({31'h0, loop_enable}, 32'h1, "engaged loop");
      check({22'h0, loop_multiplier}, 32'h200, "multiplier");
    end
    wr(OFS_C2, 8'h40);
    $display("oscillator control test done");
  endtask

  task automatic t_ext_ref;
    wr(OFS_C2, 8'h42);
    measure(100);
    near(n_ext, 20, "ext out on");
    wr(OFS_C2, 8'h40);
    measure(100);
    check(n_ext, 0, "ext out off");
    @(posedge pclk);
    stop_mode <= 1'b1;
    wr(OFS_C2, 8'h43);
    measure(100);
    near(n_ext, 20, "stop kept");
    wr(OFS_C2, 8'h42);
    measure(100);
    check(n_ext, 0, "stop off");
    @(posedge pclk);
    stop_mode <= 1'b0;
    wr(OFS_C2, 8'h40);
    $display("external reference test done");
  endtask

  task automatic t_trim;
    wr(OFS_TRIM, 8'hA5);
    wr(OFS_SC, 8'hFF);
    @(negedge pclk);
    check({23'h0, int_ref_trim}, 32'h14B, "trim fine set");
    rd(OFS_SC, 8'h01, "status read only");
    wr(OFS_SC, 8'h00);
    @(negedge pclk);
    check({23'h0, int_ref_trim}, 32'h14A, "fine clear");
    $display("trim test done");
  endtask

  task automatic t_modes;
    wr(OFS_SRC, 8'h44);
    @(negedge pclk);
    check({30'h0, mode_status}, 32'h0, "status lags");
    wait_mode(2'b01, "bypass int");
    measure(120);
    near(n_main, 20, "int source");
    check({31'h0, n_dbg > 0}, 32'h1, "bypass debug");
    wr(OFS_C2, 8'h48);
    measure(60);
    check({31'h0, loop_enable}, 32'h0, "low power loop off");
    check(n_dbg, 0, "low power no debug");
    @(posedge pclk);
    dbg <= 1'b1;
    @(negedge pclk);
    check({31'h0, loop_enable}, 32'h1, "debug keeps loop");
    @(posedge pclk);
    dbg <= 1'b0;
    wr(OFS_C2, 8'h42);
    ref_freq_ok <= 1'b1;
    wr(OFS_SRC, 8'hC4);
    wait_mode(2'b00, "code 11 loop");
    wr(OFS_SRC, 8'h80);
    wait_mode(2'b10, "bypass ext");
    check({31'h0, loop_ref_internal}, 32'h0, "ext ref loop");
    measure(120);
    near(n_main, 12, "ext source");
    wr(OFS_C2, 8'h4A);
    measure(40);
    check({31'h0, loop_enable}, 32'h0, "ext low power loop off");
    check({30'h0, mode_status}, 32'h2, "ext low power status");
    wr(OFS_C2, 8'h42);
    wr(OFS_SRC, 8'h00);
    wait_mode(2'b00, "engaged ext");
    check({31'h0, ext_ref_osc_en}, 32'h1, "engaged ext on");
    measure(120);
    near(n_rdt, 24, "ref div 1");
    wr(OFS_SRC, 8'h18);
    measure(240);
    near(n_rdt, 6, "ref div 8");
    wr(OFS_SRC, 8'h04);
    wait_mode(2'b00, "engaged int");
    check({31'h0, loop_ref_internal}, 32'h1, "int ref loop");
    $display("mode test done");
  endtask

  task automatic t_ready;
    wr(OFS_C2, 8'h46);
    measure(80);
    rd(OFS_SC, 8'h02, "ready set");
    wr(OFS_C2, 8'h42);
    rd(OFS_SC, 8'h00, "ready cleared");
    $display("ready test done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bus_div();
    t_osc_bits();
    t_ext_ref();
    t_trim();
    t_modes();
    t_ready();
    tally_and_finish();
  end

  // the run needs about 2500 cycles; allow sixteen times that
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule // csu_top_tb
`default_nettype wire
